/* burst_sram_pkg.sv */
// package: constants and carriers for the burst sram control block
package burst_sram_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS        = 8'h00; // mode straps and sleep
   localparam logic [7:0] STATUS_OFS      = 8'h04; // burst state, read only
   localparam logic [7:0] MEM_ADDR_OFS    = 8'h08; // backdoor word address
   localparam logic [7:0] MEM_DATA_OFS    = 8'h0C; // backdoor word data
   // control field positions
   localparam int LINEAR_BIT_POS          = 0;
   localparam int FLOWTHRU_BIT_POS        = 1;
   localparam int DESELECT_BIT_POS        = 2;
   localparam int SLEEP_BIT_POS           = 3;
   localparam int DRIVE_BIT_POS           = 4;
   // control reset: straps at their default levels
   localparam logic [4:0] CTRL_RESET      = 5'h16;
   localparam int LANES                   = 2;
   localparam int LANE_W                  = 9;
   localparam int ADDR_W                  = 8;

   // one synchronous command sampled at the clock edge
   typedef struct packed {
      logic                chip_select_n;
      logic                proc_addr_strobe_n;
      logic                ctrl_addr_strobe_n;
      logic                burst_advance_n;
      logic                global_write_n;
      logic                byte_write_qual_n;
      logic [LANES-1:0]    lane_write_sel_n;
      logic [ADDR_W-1:0]   addr;
   } sram_cmd_t;

   // mode straps
   typedef struct packed {
      logic drive_strength_sel;
      logic sleep_req;
      logic deselect_mode_sel;
      logic flowthru_sel_n;
      logic linear_order_sel_n;
   } sram_mode_t;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} burst_state_t;
endpackage : burst_sram_pkg

/* burst_sram_ctrl.sv */
// synchronous burst sram core with mode straps and ahb-lite register port
// Notes on behaviour
// (RULE1) low address bits preset the burst counter
// (RULE2) each lane has own active-low write select
// (RULE3) byte qualifier writes only selected lanes
// (RULE4) global write writes every lane
// (RULE5) chip select low selects new access
// (RULE6) counter steps only while advance asserted
// (RULE7) either active-low strobe starts a burst
// (RULE8) data driven only while output enable low
// (RULE9) order strap: low linear, high interleaved
// (RULE10) output strap: low flow-through, high pipelined
// (RULE11) sleep high gives standby, low normal
// (RULE12) deselect strap: low dual, high single
// (RULE13) unconnected straps fall to default levels
// (RULE14) linear order increments modulo four
// (RULE15) interleaved order is preset xor count
// (RULE16) selected strobe starts burst at external address
// (RULE17) advance continues burst, else suspend
// (RULE18) output enable high disables drivers at once
// (RULE19) reads with outputs off still advance counter
// (RULE20) straps held static by the outside party
// (RULE21) flow-through same cycle, pipeline one later
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
module burst_sram_ctrl
   import burst_sram_pkg::*;
#(
   parameter int DEPTH = 256
) (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire sram_cmd_t                 cmd,
   input  wire logic [LANES*LANE_W-1:0]   dq_in,
   output logic      [LANES*LANE_W-1:0]   dq_out,
   output logic      [LANES-1:0]          dq_oe,
   input  wire logic                      output_en_n,
   input  wire logic                      strap_sleep_req,
   input  wire logic                      strap_linear_order_sel_n,
   input  wire logic                      strap_flowthru_sel_n,
   input  wire logic                      strap_deselect_mode_sel,
   input  wire logic                      strap_drive_strength_sel,
   input  wire logic                      strap_use_pins,
   output logic                           drive_strength_out,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hsel,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp
);
   localparam int DW = LANES*LANE_W;

   if (DEPTH != (1 << ADDR_W)) begin : g_depth_check
      $error("DEPTH must equal 2**ADDR_W");
   end

   logic [DW-1:0]        mem [DEPTH];
   logic [4:0]           ctrl_reg;
   logic [4:0]           ctrl_next;
   burst_state_t         state_reg;
   burst_state_t         state_next;
   logic [ADDR_W-1:0]    base_reg;
   logic [1:0]           preset_reg;
   logic [1:0]           count_reg;
   logic [DW-1:0]        pipe_reg;
   logic                 rd_act_reg;
   logic                 rd_valid_reg;
   logic                 rd_valid_d_reg;
   logic [ADDR_W-1:0]    bd_addr_reg;
   logic                 ahb_wr_reg;
   logic [7:0]           ahb_ofs_reg;
   logic                 ahb_act_reg;

   // effective mode: pins when strapped in, else software control
   sram_mode_t mode;
   assign mode = strap_use_pins ? {strap_drive_strength_sel, strap_sleep_req,
                                   strap_deselect_mode_sel, strap_flowthru_sel_n,
                                   strap_linear_order_sel_n}
                                : sram_mode_t'(ctrl_reg); // RULE13 RULE20
   wire sleep     = mode.sleep_req; // RULE11
   wire interleav = mode.linear_order_sel_n; // RULE9
   wire pipelined = mode.flowthru_sel_n; // RULE10
   wire single_ds = mode.deselect_mode_sel; // RULE12
   assign drive_strength_out = mode.drive_strength_sel;

   // command decode
   wire strobe   = ~cmd.proc_addr_strobe_n | ~cmd.ctrl_addr_strobe_n; // RULE7
   wire start    = ~sleep & ~cmd.chip_select_n & strobe; // RULE5 RULE16
   wire desel    = ~sleep & cmd.chip_select_n & ~cmd.ctrl_addr_strobe_n;
   wire cont     = ~sleep & ~start & ~desel & (state_reg != ST_IDLE);
   wire advance  = cont & ~cmd.burst_advance_n; // RULE6 RULE17
   // a processor strobe always reads; otherwise write controls decide
   wire wr_ctl   = ~cmd.global_write_n | (~cmd.byte_write_qual_n & ~&cmd.lane_write_sel_n);
   wire is_write = cmd.proc_addr_strobe_n & wr_ctl;
   wire [LANES-1:0] lane_we = {LANES{~cmd.global_write_n}} // RULE4
                  | ({LANES{~cmd.byte_write_qual_n}} & ~cmd.lane_write_sel_n); // RULE2 RULE3

   // burst address: preset from low bits, linear add or interleaved xor
   wire [1:0] cnt_step = count_reg + 2'h1; // RULE14 RULE15
   wire [1:0] seq_low  = interleav ? (preset_reg ^ cnt_step) : (preset_reg + cnt_step);
   wire [1:0] cur_low  = interleav ? (preset_reg ^ count_reg) : (preset_reg + count_reg);
   wire [1:0] use_low  = start ? cmd.addr[1:0] : (advance ? seq_low : cur_low); // RULE1
   wire [ADDR_W-1:0] use_addr = start ? cmd.addr : {base_reg[ADDR_W-1:2], use_low};
   wire act_read  = (start & ~is_write) | (cont & state_reg == ST_READ & ~wr_ctl);
   wire act_write = (start & is_write) | (cont & wr_ctl);

   // next burst state
   always_comb begin
      state_next = state_reg;
      if (start) begin
         state_next = is_write ? ST_WRITE : ST_READ;
      end else if (desel) begin
         state_next = ST_IDLE;
      end else if (cont & wr_ctl) begin
         state_next = ST_WRITE;
      end
   end

   // burst registers; counter moves on advance, reads with oe high included
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg  <= ST_IDLE;
         base_reg   <= '0;
         preset_reg <= 2'h0;
         count_reg  <= 2'h0;
      end else begin
         state_reg <= state_next;
         if (start) begin
            base_reg   <= cmd.addr; // RULE1
            preset_reg <= cmd.addr[1:0];
            count_reg  <= 2'h0;
         end else if (advance) begin
            count_reg <= cnt_step; // RULE6 RULE19
         end
      end
   end

   // array write, every enabled lane in the same clock; backdoor over the bus too
   always_ff @(posedge mclk) begin
      for (int l = 0; l < LANES; l++) begin
         if (act_write & lane_we[l])
            mem[use_addr][l*LANE_W +: LANE_W] <= dq_in[l*LANE_W +: LANE_W]; // RULE3
      end
      if (ahb_act_reg & ahb_wr_reg & ahb_ofs_reg == MEM_DATA_OFS)
         mem[bd_addr_reg] <= hwdata[DW-1:0];
   end

   // read path: data captured at the edge the address is taken
   always_ff @(posedge mclk) begin
      if (reset) begin
         pipe_reg       <= '0;
         rd_act_reg     <= 1'b0;
         rd_valid_reg   <= 1'b0;
         rd_valid_d_reg <= 1'b0;
      end else begin
         if (act_read)
            pipe_reg <= mem[use_addr];
         rd_act_reg     <= act_read;
         // dual deselect keeps drivers one cycle past the last read unless a write follows, no longer
         rd_valid_reg   <= act_read | (~single_ds & rd_act_reg & ~act_write & ~start); // RULE12
         rd_valid_d_reg <= rd_valid_reg;
      end
   end

   // flow-through shows captured word at once; pipeline one clock later
   logic [DW-1:0] out_reg;
   always_ff @(posedge mclk) begin
      if (reset)
         out_reg <= '0;
      else
         out_reg <= pipe_reg; // RULE21
   end
   wire drv_active = pipelined ? rd_valid_d_reg : rd_valid_reg; // RULE10 RULE21
   assign dq_out = pipelined ? out_reg : pipe_reg;
   assign dq_oe  = {LANES{drv_active & ~output_en_n & ~sleep}}; // RULE8 RULE18

   // ahb-lite slave: zero wait, always okay
   wire ahb_go = hsel & hready & htrans[1];
   always_ff @(posedge mclk) begin
      if (reset) begin
         ahb_act_reg <= 1'b0;
         ahb_wr_reg  <= 1'b0;
         ahb_ofs_reg <= 8'h00;
      end else begin
         ahb_act_reg <= ahb_go;
         ahb_wr_reg  <= hwrite;
         ahb_ofs_reg <= haddr[7:0];
      end
   end
   wire wr_ctrl = ahb_act_reg & ahb_wr_reg & ahb_ofs_reg == CTRL_OFS;
   assign ctrl_next = wr_ctrl ? hwdata[4:0] : ctrl_reg;
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_reg    <= CTRL_RESET; // RULE13
         bd_addr_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         if (ahb_act_reg & ahb_wr_reg & ahb_ofs_reg == MEM_ADDR_OFS)
            bd_addr_reg <= hwdata[ADDR_W-1:0];
      end
   end
   wire [31:0] status_word = {24'h000000, 1'b0, state_reg, 1'b0, drv_active, sleep, cur_low};
   always_comb begin
      unique case (ahb_ofs_reg)
         CTRL_OFS:     hrdata = {27'h0000000, ctrl_reg};
         STATUS_OFS:   hrdata = status_word;
         MEM_ADDR_OFS: hrdata = {24'h000000, bd_addr_reg};
         MEM_DATA_OFS: hrdata = {14'h0000, mem[bd_addr_reg]};
         default:      hrdata = 32'h00000000;
      endcase
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;


   // output enable high keeps every driver off
   oe_gate_a: assert property (@(posedge mclk) disable iff (reset) // RULE8
      output_en_n |-> dq_oe == '0)
      else $error("drivers on with oe high");

   // no advance: the counter holds
   hold_cnt_a: assert property (@(posedge mclk) disable iff (reset) // RULE6
      (cont & cmd.burst_advance_n) |=> $stable(count_reg))
      else $error("count moved");

   // every advance steps the counter, reads with oe high too
   step_cnt_a: assert property (@(posedge mclk) disable iff (reset) // RULE19
      advance |=> count_reg == 2'($past(count_reg) + 2'h1))
      else $error("count no step");

   // a burst start loads the preset from the low address bits
   preset_load_a: assert property (@(posedge mclk) disable iff (reset) // RULE1
      start |=> preset_reg == $past(cmd.addr[1:0]) && count_reg == 2'h0)
      else $error("preset not loaded");

   // the fifth address is the first again
   wrap_a: assert property (@(posedge mclk) disable iff (reset) // RULE15
      (advance && count_reg == 2'h3) |=> cur_low == preset_reg)
      else $error("no wrap");

   // sleep freezes the burst state
   sleep_idle_a: assert property (@(posedge mclk) disable iff (reset) // RULE11
      sleep |=> $stable(state_reg))
      else $error("active in sleep");

   // flow-through drives the cycle after the read is taken
   flow_out_a: assert property (@(posedge mclk) disable iff (reset) // RULE21
      (act_read & ~pipelined & ~output_en_n & ~sleep) ##1 (~pipelined & ~output_en_n & ~sleep)
      |-> dq_oe != '0)
      else $error("flow data late");

   // pipeline drives two cycles after the read is taken
   pipe_out_a: assert property (@(posedge mclk) disable iff (reset) // RULE10
      (act_read & pipelined) ##1 pipelined ##1 (pipelined & ~output_en_n & ~sleep)
      |-> dq_oe != '0)
      else $error("pipe data late");

   // global write enables every lane
   gw_all_a: assert property (@(posedge mclk) disable iff (reset) // RULE4
      ~cmd.global_write_n |-> &lane_we)
      else $error("global write partial");

   // without global write an unselected lane is never written
   lane_unsel_a: assert property (@(posedge mclk) disable iff (reset) // RULE3
      cmd.global_write_n |-> (lane_we & cmd.lane_write_sel_n) == '0)
      else $error("unselected lane written");

   // lane selects alone write nothing without the qualifier
   byte_qual_a: assert property (@(posedge mclk) disable iff (reset) // RULE2
      (cmd.global_write_n & cmd.byte_write_qual_n) |-> lane_we == '0)
      else $error("lane written without qualifier");

   // chip select high never starts an access
   sel_needed_a: assert property (@(posedge mclk) disable iff (reset) // RULE5
      cmd.chip_select_n |-> !start)
      else $error("start while deselected");

   // controller strobe with chip selected opens a burst
   strobe_start_a: assert property (@(posedge mclk) disable iff (reset) // RULE7
      (~sleep & ~cmd.chip_select_n & ~cmd.ctrl_addr_strobe_n) |=> state_reg != ST_IDLE)
      else $error("strobe ignored");

   // a start takes the external address
   base_load_a: assert property (@(posedge mclk) disable iff (reset) // RULE16
      start |=> base_reg == $past(cmd.addr))
      else $error("external address lost");

   // a processor strobe always begins a read
   proc_read_a: assert property (@(posedge mclk) disable iff (reset) // RULE16
      (start & ~cmd.proc_addr_strobe_n) |=> state_reg == ST_READ)
      else $error("processor strobe not read");

   // suspend keeps the burst on its current address
   suspend_a: assert property (@(posedge mclk) disable iff (reset) // RULE17
      (cont & cmd.burst_advance_n) |=> $stable(preset_reg) && $stable(count_reg))
      else $error("suspend moved address");

   // linear order adds one modulo four
   linear_step_a: assert property (@(posedge mclk) disable iff (reset) // RULE14
      (advance & ~interleav) ##1 ~interleav |-> cur_low == 2'($past(cur_low) + 2'h1))
      else $error("linear step wrong");

   // interleaved order is preset xor the new count
   ilv_step_a: assert property (@(posedge mclk) disable iff (reset) // RULE15
      (advance & interleav) ##1 interleav
      |-> cur_low == ($past(preset_reg) ^ 2'($past(count_reg) + 2'h1)))
      else $error("interleaved step wrong");

   // single deselect drops drivers once reads stop
   single_off_a: assert property (@(posedge mclk) disable iff (reset) // RULE12
      (single_ds & ~act_read) |=> !rd_valid_reg)
      else $error("single deselect late");

   // dual deselect holds drivers one cycle after the last read
   dual_hold_a: assert property (@(posedge mclk) disable iff (reset) // RULE12
      (~single_ds & act_read) ##1 (~single_ds & ~act_read & ~act_write & ~start) |=> rd_valid_reg)
      else $error("dual deselect early");

   // dual deselect releases after that one cycle
   dual_end_a: assert property (@(posedge mclk) disable iff (reset) // RULE12
      (~single_ds & ~act_read) ##1 ~act_read |=> !rd_valid_reg)
      else $error("dual deselect held too long");
endmodule : burst_sram_ctrl

/* sram_host_model.sv */
// host-side model that drives the synchronous sram command port
module sram_host_model
   import burst_sram_pkg::*;
(
   input  wire logic                  mclk,
   output sram_cmd_t                  cmd,
   output logic [LANES*LANE_W-1:0]    dq_in,
   output logic                       output_en_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus: deselected, no strobes, outputs allowed
   initial begin
      cmd         = '1;
      dq_in       = '0;
      output_en_n = 1'b0;
   end
   // one command per clock; ctl is cs, proc strobe, ctrl strobe, advance, global wr, byte wr
   task automatic cyc(input logic [5:0] ctl, input logic [LANES-1:0] sel,
                      input logic [ADDR_W-1:0] a, input logic [17:0] d, input logic oe_n);
      @(posedge mclk);
      cmd         <= {ctl, sel, a};
      output_en_n <= oe_n;
      // released data lines toggle so a stale value can never pass as written data
      dq_in       <= (!ctl[1] || (!ctl[0] && !(&sel))) ? d : ~dq_in;
   endtask : cyc
endmodule : sram_host_model

/* sync_burst_sram_control_modes_tb_top.sv */
// testbench: burst counter, write lanes, output modes and straps of the sram block
module sync_burst_sram_control_modes_tb_top
   import burst_sram_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                      mclk = 1'b0;
   logic                      reset = 1'b1;
   sram_cmd_t                 cmd;
   logic [17:0]               dq_in, dq_out;
   logic [1:0]                dq_oe, htrans = '0;
   logic                      output_en_n, drive_strength_out, hreadyout, hresp;
   logic                      hwrite = 1'b0, hsel = 1'b0, use_pins = 1'b0, flow = 1'b0, ilv = 1'b0;
   logic [4:0]                pins = 5'h16;
   logic [31:0]               haddr = '0, hwdata = '0, hrdata, rd;
   logic [2:0]                hsize = 3'h2;
   logic [17:0]               exp_mem [256];
   logic [3:0]                tag = '0;
   int                        fail_count = 0, check_count = 0;

   always #50 mclk = ~mclk;
   // pins held at one level until the last burst, then set to 5'h05 and switched in
   burst_sram_ctrl u_dut (.mclk(mclk), .reset(reset), .cmd(cmd), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .output_en_n(output_en_n), .strap_linear_order_sel_n(pins[0]),
      .strap_flowthru_sel_n(pins[1]), .strap_deselect_mode_sel(pins[2]),
      .strap_sleep_req(pins[3]), .strap_drive_strength_sel(pins[4]), .strap_use_pins(use_pins),
      .drive_strength_out(drive_strength_out), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   sram_host_model u_host (.mclk(mclk), .cmd(cmd), .dq_in(dq_in), .output_en_n(output_en_n));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         chk("hready wait", 1, 0);
         stop_test();
      end
   endtask : wait_rdy
   // one single-word ahb-lite transfer
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, w};
      wait_rdy();
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
      wait_rdy();
      rd = hrdata;
   endtask : ahb
   task automatic set_mode(input logic [4:0] v);
      ahb(1'b1, CTRL_OFS, {27'h0, v});
      flow = !v[FLOWTHRU_BIT_POS];
      ilv  = v[LINEAR_BIT_POS];
   endtask : set_mode
   // burst of n commands from address a; reads checked at the mode's latency
   task automatic burst(input logic [5:0] c0, input logic [1:0] sel, input logic [7:0] a,
                        input int n, input int off, input logic hold, input logic en);
      logic [7:0] q [$];
      logic [7:0] ad;
      logic [17:0] d;
      int lat;
      lat = flow ? 1 : 2;
      tag++;
      for (int j = 0; j < n + lat + 1; j++) begin
         // start address preset, then linear add or interleaved xor
         ad = {a[7:2], hold ? a[1:0] : (ilv ? a[1:0] ^ 2'(j) : a[1:0] + 2'(j))};
         d  = {tag, ad, 2'(j), 4'h5};
         u_host.cyc(j == 0 ? c0 : (j < n ? {3'b111, hold, c0[1:0]} : 6'h3F), sel, ad, d,
                    j >= lat && j < lat + off);
         q.push_back(ad);
         for (int l = 0; l < 2; l++) begin
            if (j < n && en && (!c0[1] || (!c0[0] && !sel[l]))) begin
               exp_mem[ad][l*9 +: 9] = d[l*9 +: 9];
            end
         end
         #1;
         if (c0[1] && c0[0] && j >= lat && j < n + lat) begin
            if (output_en_n) begin
               chk("dq_oe off", 0, dq_oe);
            end else begin
               chk("dq_out", exp_mem[q[j-lat]], dq_out);
            end
         end
      end
   endtask : burst
   // read, then deselect: drivers held one cycle only in dual deselect mode
   task automatic desel_test(input logic [4:0] v, input logic [1:0] held);
      set_mode(v);
      burst(6'b001111, 2'b11, 8'h12, 1, 0, 1'b0, 1'b0);
      u_host.cyc(6'b110111, 2'b11, 8'h12, 18'h00000, 1'b0);
      @(posedge mclk);
      #1;
      chk("dq_oe after deselect", held, dq_oe);
      @(posedge mclk);
      #1;
      chk("dq_oe released", 0, dq_oe);
   endtask : desel_test

   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      ahb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h16, rd[4:0]);
      chk("drive strap", 1, drive_strength_out);
      burst(6'b010101, 2'b11, 8'h12, 4, 0, 1'b0, 1'b1);
      burst(6'b001111, 2'b11, 8'h12, 5, 0, 1'b0, 1'b0);
      set_mode(5'h15);
      burst(6'b010111, 2'b11, 8'h11, 5, 2, 1'b0, 1'b0);
      burst(6'b010110, 2'b10, 8'h11, 1, 0, 1'b0, 1'b1);
      burst(6'b001111, 2'b11, 8'h11, 3, 0, 1'b1, 1'b0);
      burst(6'b110101, 2'b11, 8'h10, 1, 0, 1'b0, 1'b0);
      set_mode(5'h1D);
      burst(6'b010101, 2'b11, 8'h13, 1, 0, 1'b0, 1'b0);
      set_mode(5'h15);
      burst(6'b001111, 2'b11, 8'h10, 4, 0, 1'b0, 1'b0);
      desel_test(5'h15, 2'b00);
      desel_test(5'h11, 2'b11);
      pins     <= 5'h05;
      use_pins <= 1'b1;
      burst(6'b001111, 2'b11, 8'h12, 2, 0, 1'b0, 1'b0);
      chk("drive pin", 0, drive_strength_out);
      stop_test();
   end
endmodule : sync_burst_sram_control_modes_tb_top
